// ===== async_memory_strobe_timing.sv
// Asynchronous memory strobe sequencer with APB register access
// Notes on behaviour
// - Strobes stay low for wait-state periods
// - Address, selects held read-hold after read
// - Address, data held write-hold after write
// - Address and select lead strobe at least one period
// - Same-bank reads: hold, plus one if idle
// - Cross-bank reads: read hold plus idle
// - Read then write: hold plus max(idle,4)
// - Prefetch off: hold+3, or hold+max(idle,3)
// - Write to write: one plus write hold
// - Write to read: three plus write hold
// - Drive data before write; release before read
// - Sequencing only for asynchronous mode banks
`timescale 1ns/100ps
`default_nettype none
module async_memory_strobe_timing (
	input  wire logic                              clock,
	input  wire logic                              rstn,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [7:0]                        paddr,
	input  wire logic [mem_strobe_pkg::DATA_W-1:0] pwdata,
	output var  logic [mem_strobe_pkg::DATA_W-1:0] prdata,
	output wire logic                              pready,
	output wire logic                              pslverr,
	output var  logic [mem_strobe_pkg::ADDR_W-1:0] memAddress,
	output var  logic [mem_strobe_pkg::BANKS-1:0]  bank_select_n,
	output var  logic                              mem_read_strobe_n,
	output var  logic                              mem_write_strobe_n,
	output var  logic [mem_strobe_pkg::DATA_W-1:0] memDataOut,
	output var  logic                              memDataOe,
	input  wire logic [mem_strobe_pkg::DATA_W-1:0] memDataIn,
	input  wire logic                              mem_ack_in
);
	import mem_strobe_pkg::*;

	seq_state_type     state;         // Sequencer state
	bank_timing_type   cfg;           // Timing set of the current bank
	bank_timing_type   busCfg;        // Timing set read by software
	bank_timing_type   prevCfg;       // Timing set of the previous access
	logic [ADDR_W-1:0] reqAddress;    // Address register
	logic [DATA_W-1:0] reqData;       // Write data register
	logic [DATA_W-1:0] readData;      // Captured read data
	logic              reqWrite;      // Direction of pending access
	logic [BANK_W-1:0] reqBank;       // Bank of pending access
	logic              prevValid;     // A previous access exists
	logic              prevWrite;     // Previous access was a write
	logic [BANK_W-1:0] prevBank;      // Bank of previous access
	logic [CNT_W-1:0]  sinceRise;     // Strobe-high periods since rise
	logic [CNT_W-1:0]  phaseCount;    // Periods spent in strobe or hold
	logic              doneFlag;      // Access finished, sticky
	logic              modeErr;       // Access refused, sticky
	logic              accessWait;    // First access-phase cycle seen

	// Bus decode
	wire busAccess = psel && penable && pready;
	wire busWrite  = busAccess && pwrite;
	wire isTiming  = paddr[7:4] == OFS_TIMING0[7:4] && paddr[1:0] == 2'b00;
	wire isAddress = paddr == OFS_ADDRESS;
	wire isWdata   = paddr == OFS_WDATA;
	wire isCommand = paddr == OFS_COMMAND;
	wire isStatus  = paddr == OFS_STATUS;
	wire isRdata   = paddr == OFS_RDATA;
	wire mapped    = isTiming || isAddress || isWdata || isCommand
		|| isStatus || isRdata;
	wire [BANK_W-1:0] busBank = paddr[BANK_W+1:2];
	wire [BANK_W-1:0] cmdBank = pwdata[CMD_BANK +: BANK_W];
	wire busy      = state != ST_IDLE;
	wire cmdTake   = busWrite && isCommand && pwdata[CMD_START] && !busy;
	wire doneClear = busWrite && isStatus && pwdata[ST_DONE];
	wire modeClear = busWrite && isStatus && pwdata[ST_MODE];

	// One wait state on every access, error for unmapped addresses
	assign pready  = psel && penable && accessWait;
	assign pslverr = pready && !mapped;

	// Per-bank timing sets; sequencer port follows the command bank
	bank_timing_store u_store (
		.clock       (clock),
		.rstn        (rstn),
		.writeEnable (busWrite && isTiming),
		.writeIndex  (busBank),
		.writeData   (bank_timing_type'(pwdata[15:0])),
		.busIndex    (busBank),
		.busData     (busCfg),
		.seqIndex    (cmdTake ? cmdBank : reqBank),
		.seqData     (cfg)
	);

	// Strobe-high gap owed to the previous access
	wire sameBank = prevBank == reqBank;
	wire [CNT_W-1:0] rHold = CNT_W'(prevCfg.readHoldCount);
	wire [CNT_W-1:0] wHold = CNT_W'(prevCfg.writeHoldCount);
	wire [CNT_W-1:0] idle  = CNT_W'(prevCfg.idleCycleCount);
	wire [CNT_W-1:0] idle4 = idle > GAP_READ_WRITE ? idle : GAP_READ_WRITE;
	wire [CNT_W-1:0] idle3 = idle > GAP_PD_READ ? idle : GAP_PD_READ;
	wire [CNT_W-1:0] sameNoPd = idle == '0 ? rHold
		: rHold + GAP_IDLE_EXTRA;
	wire [CNT_W-1:0] readRead = prevCfg.prefetchDisable
		? (sameBank ? rHold + GAP_PD_READ : rHold + idle3)
		: (sameBank ? sameNoPd : rHold + idle);
	wire [CNT_W-1:0] fromRead = reqWrite ? rHold + idle4
		: readRead;
	wire [CNT_W-1:0] fromWrite = reqWrite
		? GAP_WRITE_WRT + wHold
		: GAP_WRITE_READ + wHold;
	wire [CNT_W-1:0] gapNeed = !prevValid ? '0
		: (prevWrite ? fromWrite : fromRead);

	// Phase completion terms
	wire [CNT_W-1:0] waitNeed = cfg.waitCount == '0 ? CNT_W'(1)
		: CNT_W'(cfg.waitCount);
	wire [CNT_W-1:0] holdNeed = reqWrite ? CNT_W'(cfg.writeHoldCount)
		: CNT_W'(cfg.readHoldCount);
	wire gapMet    = {1'b0, sinceRise} + 9'd1 >= {1'b0, gapNeed};
	wire waitMet   = phaseCount + CNT_W'(1) >= waitNeed;
	wire strobeEnd = state == ST_STROBE && waitMet && mem_ack_in;
	wire holdEnd   = state == ST_HOLD && phaseCount + CNT_W'(1) >= holdNeed;
	wire accessEnd = holdEnd || (strobeEnd && holdNeed == '0);
	wire strobeLow = !mem_read_strobe_n || !mem_write_strobe_n;

	// Access sequencer
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE:   if (cmdTake) state <= ST_LOAD;
				// Non-asynchronous banks are refused here
				ST_LOAD:   state <= cfg.asyncMode ? ST_SETUP : ST_IDLE;
				// Address leads the strobe by at least a period
				ST_SETUP:  if (gapMet) state <= ST_STROBE;
				// Strobe held for wait count, stretched by ack
				ST_STROBE: if (strobeEnd) begin
					state <= holdNeed == '0 ? ST_IDLE : ST_HOLD;
				end
				ST_HOLD:   if (holdEnd) state <= ST_IDLE;
				default:   state <= ST_IDLE;
			endcase
		end
	end

	// Period counter for strobe-low and hold phases
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			phaseCount <= '0;
		end else if (state == ST_SETUP || strobeEnd) begin
			phaseCount <= '0;
		end else begin
			phaseCount <= phaseCount + CNT_W'(1);
		end
	end

	// Strobe-high run since the last rise, saturating
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sinceRise <= CNT_MAX;
		end else if (strobeEnd) begin
			sinceRise <= '0;
		end else if (!strobeLow && sinceRise != CNT_MAX) begin
			sinceRise <= sinceRise + CNT_W'(1);
		end
	end

	// Pin drive: selects, address and strobes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			memAddress         <= '0;
			bank_select_n      <= '1;
			mem_read_strobe_n  <= 1'b1;
			mem_write_strobe_n <= 1'b1;
		end else begin
			// Address and select set before the strobe falls
			if (state == ST_LOAD && cfg.asyncMode) begin
				memAddress    <= reqAddress;
				bank_select_n <= ~(BANKS'(1) << reqBank);
			end else if (accessEnd) begin
				// Released only once the hold has run
				bank_select_n <= '1;
			end
			if (state == ST_SETUP && gapMet) begin
				mem_read_strobe_n  <= reqWrite;
				mem_write_strobe_n <= !reqWrite;
			end else if (strobeEnd) begin
				mem_read_strobe_n  <= 1'b1;
				mem_write_strobe_n <= 1'b1;
			end
		end
	end

	// Write data drive, enabled from setup until hold ends
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			memDataOut <= '0;
			memDataOe  <= 1'b0;
		end else if (state == ST_LOAD && cfg.asyncMode && reqWrite) begin
			memDataOut <= reqData;
			memDataOe  <= 1'b1;
		end else if (accessEnd) begin
			memDataOe  <= 1'b0;
		end
	end

	// Read capture at the strobe rise, and previous-access record
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			readData  <= '0;
			prevValid <= 1'b0;
			prevWrite <= 1'b0;
			prevBank  <= '0;
			prevCfg   <= bank_timing_type'(TIMING_RESET);
		end else if (strobeEnd) begin
			if (!reqWrite) begin
				readData <= memDataIn;
			end
			prevValid <= 1'b1;
			prevWrite <= reqWrite;
			prevBank  <= reqBank;
			prevCfg   <= cfg;
		end
	end

	// Software registers for the pending access
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reqAddress <= '0;
			reqData    <= '0;
			reqWrite   <= 1'b0;
			reqBank    <= '0;
		end else begin
			if (busWrite && isAddress) reqAddress <= pwdata[ADDR_W-1:0];
			if (busWrite && isWdata) reqData <= pwdata;
			if (cmdTake) begin
				reqWrite <= pwdata[CMD_WRITE];
				reqBank  <= cmdBank;
			end
		end
	end

	// Sticky flags: a setting event wins over a clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			doneFlag <= 1'b0;
			modeErr  <= 1'b0;
		end else begin
			doneFlag <= accessEnd || (doneFlag && !doneClear);
			modeErr  <= (state == ST_LOAD && !cfg.asyncMode)
				|| (modeErr && !modeClear);
		end
	end

	// Bus wait state and registered read data
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			accessWait <= 1'b0;
			prdata     <= '0;
		end else begin
			accessWait <= psel && penable && !accessWait;
			if (psel && penable && !accessWait) begin
				prdata <= isTiming ? DATA_W'(busCfg)
					: isAddress ? DATA_W'(reqAddress)
					: isWdata ? reqData
					: isRdata ? readData
					: isStatus ? DATA_W'({modeErr, doneFlag, busy})
					: isCommand ? DATA_W'({reqBank, 2'b00, reqWrite, 1'b0})
					: '0;
			end
		end
	end

	// Checks: low-run length for strobe width
	logic [CNT_W-1:0] lowRun;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lowRun <= '0;
		end else begin
			lowRun <= strobeLow ? lowRun + CNT_W'(1) : '0;
		end
	end

	strobe_width_a: assert property (
		@(posedge clock) disable iff (!rstn)
		$rose(!strobeLow) |-> lowRun >= waitNeed)
		else $error("strobe shorter than wait count");

	setup_lead_a: assert property (
		@(posedge clock) disable iff (!rstn)
		$rose(strobeLow) |-> $past(bank_select_n) != '1)
		else $error("strobe fell without select lead");

	read_hold_a: assert property (
		@(posedge clock) disable iff (!rstn)
		$rose(mem_read_strobe_n) && cfg.readHoldCount != '0
		|-> $stable(memAddress) && $stable(bank_select_n)
			&& bank_select_n != '1)
		else $error("address moved inside read hold");

	write_hold_a: assert property (
		@(posedge clock) disable iff (!rstn)
		$rose(mem_write_strobe_n) && cfg.writeHoldCount != '0
		|-> memDataOe && bank_select_n != '1 && $stable(memAddress)
			&& $stable(memDataOut))
		else $error("address or data dropped inside write hold");

	write_data_a: assert property (
		@(posedge clock) disable iff (!rstn)
		$fell(mem_write_strobe_n) |-> $past(memDataOe))
		else $error("write strobe fell before data drive");

	read_release_a: assert property (
		@(posedge clock) disable iff (!rstn)
		!mem_read_strobe_n |-> !memDataOe)
		else $error("data driven during read strobe");

	strobe_gap_a: assert property (
		@(posedge clock) disable iff (!rstn)
		$rose(strobeLow) |-> $past(sinceRise) + 9'd1 >= $past(gapNeed))
		else $error("strobe-high gap too short");

	async_only_a: assert property (
		@(posedge clock) disable iff (!rstn)
		state == ST_LOAD && !cfg.asyncMode
		|=> state == ST_IDLE && !strobeLow ##1 !strobeLow)
		else $error("strobe on a non-asynchronous bank");

	ack_stretch_a: assert property (
		@(posedge clock) disable iff (!rstn)
		state == ST_STROBE && !mem_ack_in |=> strobeLow)
		else $error("strobe rose while ack low");

	read_capture_a: assert property (
		@(posedge clock) disable iff (!rstn)
		$rose(mem_read_strobe_n) |-> readData == $past(memDataIn))
		else $error("read data not captured at strobe rise");
endmodule : async_memory_strobe_timing
`default_nettype wire

// ===== bank_timing_store.sv
// Per-bank timing control storage with two registered read ports
`timescale 1ns/100ps
`default_nettype none
module bank_timing_store (
	input  wire logic                              clock,
	input  wire logic                              rstn,
	input  wire logic                              writeEnable,
	input  wire logic [mem_strobe_pkg::BANK_W-1:0] writeIndex,
	input  var  mem_strobe_pkg::bank_timing_type   writeData,
	input  wire logic [mem_strobe_pkg::BANK_W-1:0] busIndex,
	output var  mem_strobe_pkg::bank_timing_type   busData,
	input  wire logic [mem_strobe_pkg::BANK_W-1:0] seqIndex,
	output var  mem_strobe_pkg::bank_timing_type   seqData
);
	import mem_strobe_pkg::*;

	bank_timing_type entry [BANKS]; // One timing set per bank

	// Each entry loads only on its own index
	for (genvar i = 0; i < BANKS; i++) begin : g_entry
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				entry[i] <= bank_timing_type'(TIMING_RESET);
			end else if (writeEnable && writeIndex == BANK_W'(i)) begin
				entry[i] <= writeData;
			end
		end
	end

	// Registered read ports
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			busData <= bank_timing_type'(TIMING_RESET);
			seqData <= bank_timing_type'(TIMING_RESET);
		end else begin
			busData <= entry[busIndex];
			seqData <= entry[seqIndex];
		end
	end
endmodule : bank_timing_store
`default_nettype wire

// ===== mem_partner.sv
// Behavioural model of an asynchronous memory with a stretchable ready
`timescale 1ns/100ps
`default_nettype none
module mem_partner (
	input  wire logic                              clock,
	input  wire logic [mem_strobe_pkg::ADDR_W-1:0] memAddress,
	input  wire logic [mem_strobe_pkg::BANKS-1:0]  bank_select_n,
	input  wire logic                              mem_read_strobe_n,
	input  wire logic                              mem_write_strobe_n,
	input  wire logic [mem_strobe_pkg::DATA_W-1:0] memDataOut,
	input  wire logic [3:0]                        stallCycles,
	output wire logic [mem_strobe_pkg::DATA_W-1:0] memDataIn,
	output wire logic                              mem_ack_in
);
	import mem_strobe_pkg::*;
	logic [DATA_W-1:0] store [16];       // Small word array
	logic [DATA_W-1:0] lastOut   = '0;   // Last value put on the bus
	logic [3:0]        stallLeft = '0;   // Remaining stretch cycles
	logic              strobeWas = 1'b0; // Strobe state one cycle ago
	wire logic selected  = bank_select_n != '1;
	wire logic reading   = selected && !mem_read_strobe_n;
	wire logic strobeLow = !mem_read_strobe_n || !mem_write_strobe_n;
	// Released bus shows the inverse of the last value, never a stale copy
	assign memDataIn  = reading ? store[memAddress[3:0]] : ~lastOut;
	assign mem_ack_in = stallLeft == 4'h0;
	// Store writes, remember bus value, pull ready low early in the strobe
	always @(posedge clock) begin
		strobeWas <= strobeLow;
		if (reading) begin
			lastOut <= store[memAddress[3:0]];
		end
		if (selected && !mem_write_strobe_n) begin
			store[memAddress[3:0]] <= memDataOut;
		end
		if (strobeLow && !strobeWas) begin
			stallLeft <= stallCycles;
		end else if (stallLeft != 4'h0) begin
			stallLeft <= stallLeft - 4'h1;
		end
	end
endmodule : mem_partner
`default_nettype wire

// ===== mem_strobe_pkg.sv
// Package: register map, bank timing layout and sequencer states
package mem_strobe_pkg;
	localparam int unsigned BANKS  = 4;    // Number of bank selects
	localparam int unsigned BANK_W = 2;    // Bank index width
	localparam int unsigned ADDR_W = 24;   // External address width
	localparam int unsigned DATA_W = 32;   // External and bus data width
	localparam int unsigned CNT_W  = 8;    // Width of gap counters

	// Register byte offsets
	localparam logic [7:0] OFS_TIMING0 = 8'h00; // Bank 0..3 at +4 each
	localparam logic [7:0] OFS_ADDRESS = 8'h10; // Access address
	localparam logic [7:0] OFS_WDATA   = 8'h14; // Write data
	localparam logic [7:0] OFS_COMMAND = 8'h18; // Start, direction, bank
	localparam logic [7:0] OFS_STATUS  = 8'h1C; // Busy, done, mode error
	localparam logic [7:0] OFS_RDATA   = 8'h20; // Captured read data

	// Command and status bit positions
	localparam int unsigned CMD_START = 0;
	localparam int unsigned CMD_WRITE = 1;
	localparam int unsigned CMD_BANK  = 4;
	localparam int unsigned ST_BUSY   = 0;
	localparam int unsigned ST_DONE   = 1;
	localparam int unsigned ST_MODE   = 2;

	// Gap figures in memory clock periods
	localparam logic [CNT_W-1:0] GAP_READ_WRITE = 8'h04;
	localparam logic [CNT_W-1:0] GAP_PD_READ    = 8'h03;
	localparam logic [CNT_W-1:0] GAP_WRITE_READ = 8'h03;
	localparam logic [CNT_W-1:0] GAP_WRITE_WRT  = 8'h01;
	localparam logic [CNT_W-1:0] GAP_IDLE_EXTRA = 8'h01;
	localparam logic [CNT_W-1:0] CNT_MAX        = 8'hFF;

	// Per-bank timing control, low 16 bits of its register
	typedef struct packed {
		logic       asyncMode;       // Bank uses asynchronous access
		logic       prefetchDisable; // Prefetch disable
		logic [2:0] idleCycleCount;  // Idle cycles
		logic [2:0] readHoldCount;   // Read hold cycles
		logic [2:0] writeHoldCount;  // Write hold cycles
		logic [4:0] waitCount;       // Wait states, strobe width
	} bank_timing_type;

	localparam logic [15:0] TIMING_RESET = 16'h8001; // Async, one wait

	// Access sequencer states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_LOAD   = 3'b001,
		ST_SETUP  = 3'b010,
		ST_STROBE = 3'b011,
		ST_HOLD   = 3'b100
	} seq_state_type;
endpackage : mem_strobe_pkg

// ===== testbench.sv
// Self-checking bench for the asynchronous memory strobe sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import mem_strobe_pkg::*;
	logic              clock = 1'b0, rstn = 1'b0;   // Clock and reset
	logic              psel = 1'b0, penable = 1'b0; // APB request
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0000_0000;
	logic [31:0]       prdata;
	logic              pready, pslverr;
	logic [ADDR_W-1:0] memAddress;
	logic [BANKS-1:0]  bank_select_n;
	logic              mem_read_strobe_n, mem_write_strobe_n, memDataOe;
	logic [DATA_W-1:0] memDataOut, memDataIn;
	logic              mem_ack_in;
	logic [3:0]        stallCycles = 4'h0; // Ready stretch for the model
	int err_total = 0, checked = 0, testNo = 0;
	int lowCnt = 0, gapCnt = 0, leadCnt = 0, holdCnt = 0, falls = 0;
	int widthSeen = 0, holdSeen = 0, leadSeen = 0, gapSeen = 0;
	logic after = 1'b0, oeSeen = 1'b0; // After strobe; OE at strobe fall
	logic [31:0] q;                    // Read data of last transfer
	logic        e;                    // Error flag of last transfer
	wire logic strobeLow = !mem_read_strobe_n || !mem_write_strobe_n;
	wire logic selLow    = bank_select_n != '1;

	always #2.5 clock = ~clock;

	async_memory_strobe_timing async_memory_strobe_timing_i (
		.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .memAddress(memAddress),
		.bank_select_n(bank_select_n), .mem_read_strobe_n(mem_read_strobe_n),
		.mem_write_strobe_n(mem_write_strobe_n), .memDataOut(memDataOut),
		.memDataOe(memDataOe), .memDataIn(memDataIn), .mem_ack_in(mem_ack_in));
	mem_partner mem_partner_i (
		.clock(clock), .memAddress(memAddress), .bank_select_n(bank_select_n),
		.mem_read_strobe_n(mem_read_strobe_n),
		.mem_write_strobe_n(mem_write_strobe_n), .memDataOut(memDataOut),
		.stallCycles(stallCycles), .memDataIn(memDataIn),
		.mem_ack_in(mem_ack_in));

	// Measure strobe width, select lead and hold, and strobe-high gaps
	always @(posedge clock) begin
		if (strobeLow) begin
			if (lowCnt == 0) begin
				leadSeen <= leadCnt;
				gapSeen  <= gapCnt;
				oeSeen   <= memDataOe;
				falls    <= falls + 1;
			end
			lowCnt  <= lowCnt + 1;
			holdCnt <= 0;
			leadCnt <= 0;
			gapCnt  <= 0;
			after   <= 1'b1;
		end else begin
			if (lowCnt != 0) widthSeen <= lowCnt;
			lowCnt <= 0;
			gapCnt <= gapCnt + 1;
			if (selLow && after) holdCnt <= holdCnt + 1;
			if (selLow && !after) leadCnt <= leadCnt + 1;
			if (!selLow && after) begin
				holdSeen <= holdCnt;
				after    <= 1'b0;
			end
		end
	end

	// Final verdict and end of run
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	// Compare for equality, or for at least the expected figure
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input logic ge);
		logic ok;
		ok = ge ? (got >= exp) : (got === exp);
		checked++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer: setup, access, wait for pready, then release
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) err_total++;
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Start one access, wait for its end, then check the pin timing
	task automatic acc(input logic [1:0] b, input logic w, input logic [7:0] a,
		input logic [31:0] d, input int ew, input int eh, input int eg);
		int n;
		n = 0;
		apb(1'b1, OFS_ADDRESS, 32'(a));
		apb(1'b1, OFS_WDATA, d);
		apb(1'b1, OFS_COMMAND, (32'(b) << CMD_BANK) | (32'(w) << CMD_WRITE)
			| 32'h0000_0001);
		do begin
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			n++;
		end while (q[ST_DONE] !== 1'b1 && n < 100);
		chk(q, 32'h0000_0002, 1'b0);
		apb(1'b1, OFS_STATUS, 32'h0000_0006);
		chk(widthSeen, ew, 1'b0);
		chk(holdSeen, eh, 1'b0);
		chk(leadSeen, 1, 1'b0);
		chk(gapSeen, eg, 1'b1);
		chk(32'(oeSeen), 32'(w), 1'b0);
		if (!w) begin
			apb(1'b0, OFS_RDATA, 32'h0000_0000);
			chk(q, d, 1'b0);
		end
		testNo++;
		$display("test %0d done", testNo);
	endtask : acc

	// Bank 1 read, then a command repeated until taken, so the
	// strobe-high gap is set by the sequencer and not by bus pacing
	task automatic b2b(input logic [1:0] b, input logic w, input int eg);
		int n;
		n = 0;
		apb(1'b1, OFS_COMMAND, 32'h0000_0011);
		do begin
			apb(1'b1, OFS_COMMAND, (32'(b) << CMD_BANK)
				| (32'(w) << CMD_WRITE) | 32'h0000_0001);
			n++;
		end while (bank_select_n[b] !== 1'b0 && n < 20);
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0000_0000);
			n++;
		end while (q[ST_BUSY] !== 1'b0 && n < 100);
		chk(q, 32'h0000_0002, 1'b0);
		apb(1'b1, OFS_STATUS, 32'h0000_0006);
		chk(gapSeen, eg, 1'b0);
		testNo++;
		$display("test %0d done", testNo);
	endtask : b2b

	// Timing word: wait, write hold, read hold, idle, prefetch off, async
	function automatic logic [31:0] tm(input logic [4:0] w,
		input logic [2:0] wh, input logic [2:0] rh, input logic [2:0] ic,
		input logic pd, input logic as);
		return {16'h0000, as, pd, ic, rh, wh, w};
	endfunction : tm

	// Hang guard
	initial begin
		#100000;
		err_total++;
		summarize();
	end

	// Main sequence
	initial begin
		int f0;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, OFS_TIMING0 + 8'(4 * k), 32'h0000_0000);
			chk(q, 32'h0000_8001, 1'b0);
		end
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk(32'(e), 32'h0000_0001, 1'b0);
		chk(q, 32'h0000_0000, 1'b0);
		apb(1'b1, OFS_TIMING0, tm(5'd3, 3'd2, 3'd5, 3'd0, 1'b0, 1'b1));
		apb(1'b1, 8'h04, tm(5'd2, 3'd1, 3'd1, 3'd6, 1'b1, 1'b1));
		apb(1'b1, 8'h08, tm(5'd1, 3'd0, 3'd0, 3'd0, 1'b0, 1'b0));
		apb(1'b1, 8'h0C, tm(5'd4, 3'd0, 3'd0, 3'd2, 1'b0, 1'b1));
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(q, tm(5'd2, 3'd1, 3'd1, 3'd6, 1'b1, 1'b1), 1'b0);
		acc(2'd0, 1'b1, 8'h03, 32'hA5A5_0001, 3, 2, 0);
		acc(2'd0, 1'b1, 8'h05, 32'h5A5A_0002, 3, 2, 3);
		acc(2'd0, 1'b0, 8'h03, 32'hA5A5_0001, 3, 5, 5);
		acc(2'd0, 1'b0, 8'h05, 32'h5A5A_0002, 3, 5, 5);
		stallCycles <= 4'h3;
		acc(2'd1, 1'b0, 8'h03, 32'hA5A5_0001, 5, 1, 5);
		stallCycles <= 4'h0;
		acc(2'd1, 1'b0, 8'h05, 32'h5A5A_0002, 2, 1, 4);
		acc(2'd0, 1'b0, 8'h03, 32'hA5A5_0001, 3, 5, 7);
		acc(2'd3, 1'b1, 8'h07, 32'hC3C3_0003, 4, 0, 9);
		acc(2'd3, 1'b0, 8'h07, 32'hC3C3_0003, 4, 0, 3);
		acc(2'd3, 1'b0, 8'h07, 32'hC3C3_0003, 4, 0, 1);
		b2b(2'd0, 1'b0, 7);
		b2b(2'd3, 1'b1, 7);
		f0 = falls;
		apb(1'b1, OFS_COMMAND, 32'h0000_0021);
		repeat (4) apb(1'b0, OFS_STATUS, 32'h0000_0000);
		chk(q, 32'h0000_0004, 1'b0);
		chk(falls, f0, 1'b0);
		apb(1'b1, OFS_STATUS, 32'h0000_0006);
		$display("test mode done");
		summarize();
	end
endmodule : testbench
`default_nettype wire
